// ### uart_rx_defines.svh
`ifndef UART_RX_DEFINES_SVH
`define UART_RX_DEFINES_SVH

`define SAMPLES_NORMAL     5'h10
`define SAMPLES_DOUBLE     5'h08
`define VOTE_FIRST_NORMAL  5'h08
`define VOTE_FIRST_DOUBLE  5'h04
`define VOTE_LAST_NORMAL   5'h0A
`define VOTE_LAST_DOUBLE   5'h06
`define RESTART_DOUBLE     5'h07
`define POS_IDLE           5'h00
`define POS_FIRST          5'h01
`define POS_STEP           5'h01
`define IDX_STEP           4'h1
`define IDX_ZERO           4'h0
`define DATA_CLEAR         9'h000
`define VOTE_CLEAR         3'h0

`endif

// ### uart_rx_pkg.sv
package uart_rx_pkg;

    typedef enum logic [2:0]
    {
        RX_IDLE   = 3'h0,
        RX_START  = 3'h1,
        RX_DATA   = 3'h3,
        RX_PARITY = 3'h2,
        RX_STOP   = 3'h6,
        RX_TAIL   = 3'h7
    } rx_state_e;

    typedef struct packed
    {
        logic       valid;
        logic [8:0] data;
        logic       parity;
        logic       frame_error_flag;
    } rx_frame_s;

    typedef struct packed
    {
        logic       sync_first;
        logic       sync_second;
        rx_state_e  state;
        logic [4:0] pos;
        logic [2:0] vote;
        logic       last;
        logic [3:0] bit_idx;
        rx_frame_s  frame;
    } rx_core_s;

endpackage

// ### uart_async_rx_recovery.sv
`timescale 1ns/10ps
`default_nettype none
`include "uart_rx_defines.svh"

module uart_async_rx_recovery
(
    input  wire logic               core_clk,
    input  wire logic               reset,
    input  wire logic               rx_line,
    input  wire logic               sample_tick,
    input  wire logic               double_speed_select,
    input  wire logic [3:0]         data_bits,
    input  wire logic               parity_enable,
    output var  uart_rx_pkg::rx_frame_s rx_frame
);
    import uart_rx_pkg::*;

    ////////////////////////////////////////////////////////////////////////////

    function automatic logic majority3(input logic [2:0] s);
        majority3 = (s[0] & s[1]) | (s[0] & s[2]) | (s[1] & s[2]);
    endfunction

    // Mode decode: samples per bit and vote window
    function automatic logic [4:0] samples_per_bit(input logic dbl);
        if (dbl)
        begin
            samples_per_bit = `SAMPLES_DOUBLE;
        end
        else
        begin
            samples_per_bit = `SAMPLES_NORMAL;
        end
    endfunction

    function automatic logic [4:0] vote_first_pos(input logic dbl);
        if (dbl)
        begin
            vote_first_pos = `VOTE_FIRST_DOUBLE;
        end
        else
        begin
            vote_first_pos = `VOTE_FIRST_NORMAL;
        end
    endfunction

    function automatic logic [4:0] vote_last_pos(input logic dbl);
        if (dbl)
        begin
            vote_last_pos = `VOTE_LAST_DOUBLE;
        end
        else
        begin
            vote_last_pos = `VOTE_LAST_NORMAL;
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////

    // Idle line, idle state, empty frame
    localparam rx_core_s idle_core =
    '{
        sync_first:  1'b1,
        sync_second: 1'b1,
        state:       RX_IDLE,
        pos:         `POS_IDLE,
        vote:        `VOTE_CLEAR,
        last:        1'b1,
        bit_idx:     `IDX_ZERO,
        frame:       '{valid: 1'b0, data: `DATA_CLEAR, parity: 1'b0, frame_error_flag: 1'b0}
    };

    rx_core_s cur;
    rx_core_s next_cur;

    always_comb
    begin
        logic [4:0] spb;
        logic [4:0] vote_first;
        logic [4:0] vote_last;
        logic       sample;
        logic       bit_value;
        logic       at_wrap;
        logic       at_vote;
        logic [4:0] here;
        spb        = `SAMPLES_NORMAL;
        vote_first = `VOTE_FIRST_NORMAL;
        vote_last  = `VOTE_LAST_NORMAL;
        sample     = 1'b1;
        bit_value  = 1'b1;
        at_wrap    = 1'b0;
        at_vote    = 1'b0;
        here       = `POS_IDLE;
        next_cur   = cur;
        next_cur.frame.valid = 1'b0;
        // Two-stage synchroniser on the pin
        next_cur.sync_first  = rx_line;
        next_cur.sync_second = cur.sync_first;
        // Mode picks sample count and vote window
        spb        = samples_per_bit(double_speed_select);
        vote_first = vote_first_pos(double_speed_select);
        vote_last  = vote_last_pos(double_speed_select);
        if (sample_tick)
        begin
            sample    = cur.sync_second;
            at_wrap   = (cur.pos == spb);
            // Number of the sample taken on this tick
            here      = at_wrap ? `POS_FIRST : 5'(cur.pos + `POS_STEP);
            at_vote   = (here == vote_last);
            bit_value = majority3({cur.vote[1:0], sample});
            next_cur.last = sample;
            if (cur.state != RX_IDLE)
            begin
                // Sample state numbering within a bit
                next_cur.pos = here;
                if (here >= vote_first && here <= vote_last)
                begin
                    next_cur.vote = {cur.vote[1:0], sample};
                end
            end
            case (cur.state)
                RX_IDLE:
                begin
                    next_cur.pos = `POS_IDLE;
                    if (cur.last && !sample)
                    begin
                        next_cur.pos   = `POS_FIRST;
                        next_cur.state = RX_START;
                        next_cur.vote  = `VOTE_CLEAR;
                    end
                end
                RX_START:
                begin
                    if (at_vote && bit_value)
                    begin
                        // Noise spike, back to edge search
                        next_cur.state = RX_IDLE;
                        next_cur.pos   = `POS_IDLE;
                    end
                    else if (at_wrap)
                    begin
                        // Bit timing now locked to this start bit
                        next_cur.state      = RX_DATA;
                        next_cur.bit_idx    = `IDX_ZERO;
                        next_cur.frame.data = `DATA_CLEAR;
                    end
                end
                RX_DATA:
                begin
                    if (at_vote)
                    begin
                        next_cur.frame.data[cur.bit_idx] = bit_value;
                    end
                    if (at_wrap)
                    begin
                        next_cur.bit_idx = 4'(cur.bit_idx + `IDX_STEP);
                        if (cur.bit_idx == data_bits - `IDX_STEP)
                        begin
                            next_cur.state = parity_enable ? RX_PARITY : RX_STOP;
                        end
                    end
                end
                RX_PARITY:
                begin
                    if (at_vote)
                    begin
                        next_cur.frame.parity = bit_value;
                    end
                    if (at_wrap)
                    begin
                        next_cur.state = RX_STOP;
                    end
                end
                RX_STOP:
                begin
                    if (at_vote)
                    begin
                        next_cur.frame.frame_error_flag = !bit_value;
                        next_cur.frame.valid            = 1'b1;
                        if (double_speed_select)
                        begin
                            next_cur.state = RX_TAIL;
                        end
                        else
                        begin
                            // Rearm at once; further stop bits ignored
                            next_cur.state = RX_IDLE;
                            next_cur.pos   = `POS_IDLE;
                        end
                    end
                end
                RX_TAIL:
                begin
                    if (here == `RESTART_DOUBLE)
                    begin
                        next_cur.state = RX_IDLE;
                        next_cur.pos   = `POS_IDLE;
                    end
                end
                default:
                begin
                    next_cur.state = RX_IDLE;
                    next_cur.pos   = `POS_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk or posedge reset)
    begin
        if (reset)
        begin
            cur <= idle_core;
        end
        else
        begin
            cur <= next_cur;
        end
    end

    assign rx_frame = cur.frame;

endmodule
`default_nettype wire

// ### uart_tx_model.sv
`timescale 1ns/10ps
`default_nettype none
module uart_tx_model
(
    input  wire logic core_clk,
    input  wire logic sample_tick,
    output var  logic rx_line
);
    initial rx_line = 1'b1;
    // Bits go LSB first at exactly the receiver rate; idle level is high
    // Last bit lasts tail ticks, so early starts can be sent
    task automatic send(input logic [11:0] bits, input int n, input int spb,
                        input int tail);
        for (int i = 0; i < n; i++)
        begin
            rx_line <= bits[i];
            repeat ((i == n - 1) ? tail : spb) @(posedge core_clk iff sample_tick);
        end
        if (!bits[n - 1])
        begin
            // Back to idle level after a low last bit
            rx_line <= 1'b1;
            @(posedge core_clk iff sample_tick);
        end
    endtask
endmodule
`default_nettype wire

// ### uart_rx_checker.sv
`timescale 1ns/10ps
`default_nettype none
module uart_rx_checker
(
    input wire logic                   core_clk,
    input wire logic                   reset,
    input wire logic                   rx_line,
    input wire logic                   sample_tick,
    input wire logic [3:0]             data_bits,
    input wire uart_rx_pkg::rx_frame_s rx_frame
);
    import uart_rx_pkg::*;
    logic [1:0] sync;
    logic [2:0] hist;
    logic       vote;
    assign vote = (hist[0] & hist[1]) | (hist[0] & hist[2]) | (hist[1] & hist[2]);
    // Last three ticked samples of the synchronised line
    always_ff @(posedge core_clk or posedge reset)
    begin
        if (reset)
        begin
            sync <= 2'h3;
            hist <= 3'h7;
        end
        else
        begin
            sync <= {sync[0], rx_line};
            if (sample_tick)
                hist <= {hist[1:0], sync[1]};
        end
    end
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (reset);
    sequence s_quiet;
        !rx_frame.valid [*8];
    endsequence
    sequence s_stop_voted;
        $past(sample_tick) ##0 rx_frame.valid;
    endsequence
    property p_valid_once;
        rx_frame.valid |=> s_quiet;
    endproperty
    property p_valid_tick;
        rx_frame.valid |-> $past(sample_tick);
    endproperty
    property p_fe_vote;
        s_stop_voted |-> rx_frame.frame_error_flag == !vote;
    endproperty
    property p_fe_change;
        $changed(rx_frame.frame_error_flag) |-> rx_frame.valid;
    endproperty
    property p_data_change;
        $changed(rx_frame.data) |-> $past(sample_tick);
    endproperty
    property p_par_change;
        $changed(rx_frame.parity) |-> $past(sample_tick);
    endproperty
    property p_upper_zero;
        rx_frame.valid && data_bits == 4'h5 |-> rx_frame.data[8:5] == 4'h0;
    endproperty
    property p_reset_clear;
        $fell(reset) |-> rx_frame == '0;
    endproperty
    a_valid_once: assert property (p_valid_once) else $error("valid too long");
    a_valid_tick: assert property (p_valid_tick) else $error("valid off tick");
    a_fe_vote: assert property (p_fe_vote) else $error("bad stop vote");
    a_fe_change: assert property (p_fe_change) else $error("fe moved");
    a_data_change: assert property (p_data_change) else $error("data moved");
    a_par_change: assert property (p_par_change) else $error("parity moved");
    a_upper_zero: assert property (p_upper_zero) else $error("upper data set");
    a_reset_clear: assert property (p_reset_clear) else $error("reset value");
endmodule
bind uart_async_rx_recovery uart_rx_checker u_chk
(
    .core_clk(core_clk),
    .reset(reset),
    .rx_line(rx_line),
    .sample_tick(sample_tick),
    .data_bits(data_bits),
    .rx_frame(rx_frame)
);
`default_nettype wire

// ### uart_async_rx_recovery_tb.sv
`timescale 1ns/10ps
`default_nettype none
module uart_async_rx_recovery_tb;
    import uart_rx_pkg::*;
    logic        core_clk = 1'b0;
    logic        reset = 1'b1;
    logic        sample_tick = 1'b0;
    logic        double_speed_select = 1'b0;
    logic [3:0]  data_bits = 4'h8;
    logic        parity_enable = 1'b0;
    logic        rx_line;
    logic [1:0]  div = 2'h0;
    logic [31:0] seed = 32'hE90F;
    logic [10:0] want;
    logic [10:0] exp_q[$];
    logic        last_par = 1'b0;
    int          bad_count = 0;
    int          checks = 0;
    rx_frame_s   rx_frame;
    always #5 core_clk = ~core_clk;
    always @(posedge core_clk)
    begin
        div <= div + 2'h1;
        sample_tick <= (div == 2'h3);
    end
    uart_tx_model u_uart_tx_model (.core_clk(core_clk), .sample_tick(sample_tick), .rx_line(rx_line));
    uart_async_rx_recovery u_uart_async_rx_recovery
    (
        .core_clk(core_clk), .reset(reset), .rx_line(rx_line), .sample_tick(sample_tick),
        .double_speed_select(double_speed_select), .data_bits(data_bits),
        .parity_enable(parity_enable), .rx_frame(rx_frame)
    );
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic check(input logic [10:0] seen, input logic [10:0] exp);
        checks++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("ERROR %0t got %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge core_clk iff sample_tick);
    endtask
    // Short stop: next start right after the earliest rearm point
    task automatic frame(input int n, input logic pe, input logic stop, input logic short_stop);
        logic [11:0] bits;
        logic [8:0]  d;
        int          len;
        int          spb;
        seed = lfsr(seed);
        d = seed[8:0] & ((9'h1 << n) - 9'h1);
        bits = {2'h0, d, 1'b0};
        len = n + 1;
        spb = double_speed_select ? 8 : 16;
        if (pe)
        begin
            bits[len] = seed[9];
            last_par = seed[9];
            len = len + 1;
        end
        bits[len] = stop;
        len = len + 1;
        data_bits <= 4'(n);
        parity_enable <= pe;
        // Parity output holds its last voted value when none is sent
        exp_q.push_back({d, last_par, !stop});
        u_uart_tx_model.send(bits, len, spb,
                             short_stop ? (double_speed_select ? 7 : 10) : spb);
        if (!stop)
            idle(4);
    endtask
    always @(posedge core_clk)
        if (rx_frame.valid === 1'b1)
        begin
            want = exp_q.size() > 0 ? exp_q.pop_front() : 'x;
            check({rx_frame.data, rx_frame.parity, rx_frame.frame_error_flag}, want);
        end
    initial
    begin
        repeat (10) @(posedge core_clk);
        reset <= 1'b0;
        idle(4);
        for (int m = 0; m < 2; m++)
        begin
            double_speed_select <= m[0];
            idle(2);
            for (int k = 0; k < 10; k++)
            begin
                if (k == 6)
                begin
                    u_uart_tx_model.send(12'h0, 1, 3, 3);
                    idle(16);
                end
                frame(5 + k % 5, k[0] ^ (k > 4), k != 3 && k != 8, k == 2 || k == 7);
            end
            idle(20);
            check(11'(exp_q.size()), 11'h0);
            $display("mode %0d test done", m);
        end
        wrap_up();
    end
    initial
    begin
        repeat (60000) @(posedge core_clk);
        bad_count++;
        wrap_up();
    end
endmodule
`default_nettype wire
